// ===== include/sfr_init_pkg.sv
package sfr_init_pkg;
    // register offsets (8-bit special function space)
    localparam logic [7:0] OSC_TUNE_ADDR      = 8'h96;
    localparam logic [7:0] WDOG_CTRL_ADDR     = 8'hA7;
    localparam logic [7:0] RTC_CTRL_ADDR      = 8'hD1;
    localparam logic [7:0] RTC_HIGH_ADDR      = 8'hD2;
    localparam logic [7:0] RTC_LOW_ADDR       = 8'hD3;
    localparam logic [7:0] RESET_CAUSE_ADDR   = 8'hDF;
    localparam logic [7:0] BAUD_CTRL_ADDR     = 8'hBD;
    localparam logic [7:0] BAUD_HIGH_ADDR     = 8'hBF;
    localparam logic [7:0] BAUD_LOW_ADDR      = 8'hBE;
    localparam logic [7:0] PORT_MODE_ADDR     = 8'hE0;
    localparam logic [7:0] IRQ_STATUS_ADDR    = 8'hE4;
    localparam logic [7:0] IRQ_MASK_ADDR      = 8'hE5;
    // reset-cause field positions
    localparam int RC_EXT_BIT   = 0;
    localparam int RC_SOFT_BIT  = 1;
    localparam int RC_WDOG_BIT  = 2;
    localparam int RC_BREAK_BIT = 3;
    localparam int RC_PON_BIT   = 4;
    localparam int RC_BROWN_BIT = 5;
    // watchdog control field positions
    localparam int WD_TIMEOUT_BIT = 1;
    // reset values, write masks, baud enable bit position and interrupt width
    localparam logic [7:0] RESET_CAUSE_PON = 8'h30;
    localparam logic [7:0] WDOG_CTRL_RST   = 8'hE5;
    localparam logic [7:0] RTC_CTRL_RST    = 8'h60;
    localparam logic [7:0] RTC_COUNT_RST   = 8'h00;
    localparam logic [7:0] PORT_MODE_RST   = 8'h00;
    localparam logic [7:0] ZERO_BYTE       = 8'h00;
    localparam logic [7:0] OSC_TUNE_MASK   = 8'hFF;
    localparam logic [7:0] WDOG_CTRL_WMASK = 8'hE5;
    localparam logic [7:0] RTC_CTRL_WMASK  = 8'h63;
    localparam logic [7:0] RC_FLAG_MASK    = 8'h3F;
    localparam int         BAUD_EN_BIT     = 0;
    localparam int         IRQ_BITS        = 6;
endpackage

// ===== rtl/reset_dependent_sfr_init.sv
// Implementation choice: the address-and-strobe port.
`timescale 1ns/10ps
module reset_dependent_sfr_init #(
    parameter logic [7:0] FACTORY_TUNE = 8'h20  // arbitrary factory trim default
) (
    // clock, reset, enable
    input  wire logic       clk,
    input  wire logic       nrst,
    input  wire logic       clk_en,
    // reset sources, asynchronous pins
    input  wire logic       pon_rst_pin,
    input  wire logic       brownout_rst_pin,
    input  wire logic       wdog_rst_pin,
    input  wire logic       soft_rst_pin,
    input  wire logic       ext_rst_pin,
    input  wire logic       break_rst_pin,
    // register port
    input  wire logic [7:0] addr,
    input  wire logic [7:0] wdata,
    input  wire logic       wr,
    input  wire logic       rd,
    output logic      [7:0] rdata,
    // system outputs
    output logic      [7:0] port_out_en_n,
    output logic      [7:0] osc_tune,
    output logic      [7:0] baud_divisor_high,
    output logic      [7:0] baud_divisor_low,
    output logic            baud_collision,
    output logic            irq
);
    // two-flop synchronisers for the six reset sources; a third stage keeps
    // the previous level, so each source is seen to rise once, three edges
    // after its pin, however long the pin is held
    logic [5:0] src_meta_reg, src_meta_next;
    logic [5:0] src_sync_reg, src_sync_next;
    logic [5:0] src_prev_reg, src_prev_next;
    logic [5:0] src_raw;
    logic [5:0] src_rise;
    assign src_raw  = {brownout_rst_pin, pon_rst_pin, break_rst_pin, wdog_rst_pin, soft_rst_pin, ext_rst_pin};
    assign src_rise = src_sync_reg & ~src_prev_reg;

    always_comb begin
        src_meta_next = src_raw;
        src_sync_next = src_meta_reg;
        src_prev_next = src_sync_reg;
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            src_meta_reg <= 6'h00;
            src_sync_reg <= 6'h00;
            src_prev_reg <= 6'h00;
        end else if (clk_en) begin
            src_meta_reg <= src_meta_next;
            src_sync_reg <= src_sync_next;
            src_prev_reg <= src_prev_next;
        end
    end

    // power-on state held while the power-on source is asserted; the loads
    // repeat every cycle of the pulse, so a long pulse is harmless
    logic pon_active;
    logic sys_reset;
    assign pon_active = src_sync_reg[sfr_init_pkg::RC_PON_BIT];
    assign sys_reset  = |src_sync_reg;

    // registers
    logic [7:0] cause_reg, cause_next;
    logic [7:0] wdog_reg, wdog_next;
    logic [7:0] tune_reg, tune_next;
    logic [7:0] rtc_ctrl_reg, rtc_ctrl_next;
    logic [7:0] rtc_high_reg, rtc_high_next;
    logic [7:0] rtc_low_reg, rtc_low_next;
    logic [7:0] baud_ctrl_reg, baud_ctrl_next;
    logic [7:0] baud_high_reg, baud_high_next;
    logic [7:0] baud_low_reg, baud_low_next;
    logic [7:0] port_mode_reg, port_mode_next;
    logic [5:0] irq_stat_reg, irq_stat_next;
    logic [5:0] irq_mask_reg, irq_mask_next;
    logic       collide_reg, collide_next;
    logic [7:0] rdata_reg, rdata_next;
    logic       irq_reg, irq_next;
    logic [7:0] oe_n_reg, oe_n_next;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] target);
        hit = (a == target);
    endfunction

    // masked merge: writable bits from software, read-only bits kept
    function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] data, input logic [7:0] wmask);
        merge = (data & wmask) | (old & ~wmask);
    endfunction

    // register next-state: software writes first, then reset-source effects, which override them
    always_comb begin
        cause_next     = cause_reg;
        wdog_next      = wdog_reg;
        tune_next      = tune_reg;
        rtc_ctrl_next  = rtc_ctrl_reg;
        rtc_high_next  = rtc_high_reg;
        rtc_low_next   = rtc_low_reg;
        baud_ctrl_next = baud_ctrl_reg;
        baud_high_next = baud_high_reg;
        baud_low_next  = baud_low_reg;
        port_mode_next = port_mode_reg;
        irq_mask_next  = irq_mask_reg;
        collide_next   = collide_reg;
        irq_stat_next  = irq_stat_reg;
        if (wr && hit(addr, sfr_init_pkg::IRQ_STATUS_ADDR)) begin
            irq_stat_next = irq_stat_reg & ~wdata[5:0];
        end
        irq_stat_next = irq_stat_next | src_rise;  // set wins over clear
        if (wr && hit(addr, sfr_init_pkg::RESET_CAUSE_ADDR)) begin
            cause_next = cause_reg & ~(wdata & sfr_init_pkg::RC_FLAG_MASK);  // flags cleared by writing one
        end
        if (wr && hit(addr, sfr_init_pkg::OSC_TUNE_ADDR)) begin
            tune_next = wdata & sfr_init_pkg::OSC_TUNE_MASK;
        end else if (wr && hit(addr, sfr_init_pkg::WDOG_CTRL_ADDR)) begin
            // timeout flag lies outside the write mask: only resets move it
            wdog_next = merge(wdog_reg, wdata, sfr_init_pkg::WDOG_CTRL_WMASK);
        end else if (wr && hit(addr, sfr_init_pkg::RTC_CTRL_ADDR)) begin
            // overflow flag stays read-only from this port
            rtc_ctrl_next = merge(rtc_ctrl_reg, wdata, sfr_init_pkg::RTC_CTRL_WMASK);
        end else if (wr && hit(addr, sfr_init_pkg::RTC_HIGH_ADDR)) begin
            rtc_high_next = wdata;
        end else if (wr && hit(addr, sfr_init_pkg::RTC_LOW_ADDR)) begin
            rtc_low_next = wdata;
        end else if (wr && hit(addr, sfr_init_pkg::BAUD_CTRL_ADDR)) begin
            baud_ctrl_next = wdata;
        end else if (wr && hit(addr, sfr_init_pkg::BAUD_HIGH_ADDR)) begin
            baud_high_next = wdata;
            // write while enabled is unpredictable; flag it for software
            if (baud_ctrl_reg[sfr_init_pkg::BAUD_EN_BIT]) collide_next = 1'b1;
        end else if (wr && hit(addr, sfr_init_pkg::BAUD_LOW_ADDR)) begin
            baud_low_next = wdata;
            if (baud_ctrl_reg[sfr_init_pkg::BAUD_EN_BIT]) collide_next = 1'b1;
        end else if (wr && hit(addr, sfr_init_pkg::PORT_MODE_ADDR)) begin
            port_mode_next = wdata;
            collide_next   = 1'b0;
        end else if (wr && hit(addr, sfr_init_pkg::IRQ_MASK_ADDR)) begin
            irq_mask_next = wdata[5:0];
        end
        // any reset source: system registers outside the power-on domain, except the interrupt status;
        // watchdog control keeps its settings, only its timeout flag moves
        // here, so a watchdog bite stays visible across the restart
        if (sys_reset) begin
            baud_ctrl_next = sfr_init_pkg::ZERO_BYTE;
            baud_high_next = sfr_init_pkg::ZERO_BYTE;
            baud_low_next  = sfr_init_pkg::ZERO_BYTE;
            port_mode_next = sfr_init_pkg::PORT_MODE_RST;
            collide_next   = 1'b0;
            // flags accumulate until software clears them by writing ones
            cause_next     = cause_reg | {4'h0, src_rise[3:0]};
            if (src_rise[sfr_init_pkg::RC_WDOG_BIT]) begin
                wdog_next[sfr_init_pkg::WD_TIMEOUT_BIT] = 1'b1;
            end
        end
        // power-on: restores the power-on-only registers
        if (pon_active) begin
            cause_next    = sfr_init_pkg::RESET_CAUSE_PON;
            wdog_next     = sfr_init_pkg::WDOG_CTRL_RST;
            tune_next     = FACTORY_TUNE;
            rtc_ctrl_next = sfr_init_pkg::RTC_CTRL_RST;
            rtc_high_next = sfr_init_pkg::RTC_COUNT_RST;
            rtc_low_next  = sfr_init_pkg::RTC_COUNT_RST;
            irq_mask_next = 6'h00;
        end
        // brownout alone sets its own cause flag without clearing others
        if (src_rise[sfr_init_pkg::RC_BROWN_BIT] && !pon_active) begin
            cause_next[sfr_init_pkg::RC_BROWN_BIT] = 1'b1;
        end
    end

    // read mux, data registered for the next cycle; unmapped addresses and
    // idle cycles read zero, so a stale value never looks like an answer
    always_comb begin
        rdata_next = sfr_init_pkg::ZERO_BYTE;
        if (rd) begin
            if (hit(addr, sfr_init_pkg::OSC_TUNE_ADDR)) begin
                rdata_next = tune_reg;
            end else if (hit(addr, sfr_init_pkg::WDOG_CTRL_ADDR)) begin
                rdata_next = wdog_reg;
            end else if (hit(addr, sfr_init_pkg::RTC_CTRL_ADDR)) begin
                rdata_next = rtc_ctrl_reg;
            end else if (hit(addr, sfr_init_pkg::RTC_HIGH_ADDR)) begin
                rdata_next = rtc_high_reg;
            end else if (hit(addr, sfr_init_pkg::RTC_LOW_ADDR)) begin
                rdata_next = rtc_low_reg;
            end else if (hit(addr, sfr_init_pkg::RESET_CAUSE_ADDR)) begin
                rdata_next = cause_reg;
            end else if (hit(addr, sfr_init_pkg::BAUD_CTRL_ADDR)) begin
                rdata_next = baud_ctrl_reg;
            end else if (hit(addr, sfr_init_pkg::BAUD_HIGH_ADDR)) begin
                rdata_next = baud_high_reg;
            end else if (hit(addr, sfr_init_pkg::BAUD_LOW_ADDR)) begin
                rdata_next = baud_low_reg;
            end else if (hit(addr, sfr_init_pkg::PORT_MODE_ADDR)) begin
                rdata_next = port_mode_reg;
            end else if (hit(addr, sfr_init_pkg::IRQ_STATUS_ADDR)) begin
                rdata_next = {1'b0, collide_reg, irq_stat_reg};
            end else if (hit(addr, sfr_init_pkg::IRQ_MASK_ADDR)) begin
                rdata_next = {2'b00, irq_mask_reg};
            end
        end
        irq_next = |(irq_stat_next & irq_mask_next);
        // pin enables follow the next port mode so they change with it
        oe_n_next = ~port_mode_next;
    end

    // registration; the power-on-only registers ignore nrst, which is a
    // non-power-on reset, and are initialised by the power-on source instead
    always_ff @(posedge clk) begin
        if (!nrst) begin
            baud_ctrl_reg <= sfr_init_pkg::ZERO_BYTE;
            baud_high_reg <= sfr_init_pkg::ZERO_BYTE;
            baud_low_reg  <= sfr_init_pkg::ZERO_BYTE;
            port_mode_reg <= sfr_init_pkg::PORT_MODE_RST;
            irq_stat_reg  <= 6'h00;
            collide_reg   <= 1'b0;
        end else if (clk_en) begin
            baud_ctrl_reg <= baud_ctrl_next;
            baud_high_reg <= baud_high_next;
            baud_low_reg  <= baud_low_next;
            port_mode_reg <= port_mode_next;
            irq_stat_reg  <= irq_stat_next;
            collide_reg   <= collide_next;
        end
    end

    // output flops: read data, interrupt and pin enables come straight from
    // here; the enables restart released so no pin is driven before software
    // has chosen an output mode
    always_ff @(posedge clk) begin
        if (!nrst) begin
            rdata_reg <= sfr_init_pkg::ZERO_BYTE;
            irq_reg   <= 1'b0;
            oe_n_reg  <= ~sfr_init_pkg::PORT_MODE_RST;
        end else if (clk_en) begin
            rdata_reg <= rdata_next;
            irq_reg   <= irq_next;
            oe_n_reg  <= oe_n_next;
        end
    end

    // power-on domain registers
    always_ff @(posedge clk) begin
        if (clk_en) begin
            cause_reg    <= cause_next;
            wdog_reg     <= wdog_next;
            tune_reg     <= tune_next;
            rtc_ctrl_reg <= rtc_ctrl_next;
            rtc_high_reg <= rtc_high_next;
            rtc_low_reg  <= rtc_low_next;
            irq_mask_reg <= irq_mask_next;
        end
    end

    assign rdata             = rdata_reg;
    assign port_out_en_n     = oe_n_reg;
    assign osc_tune          = tune_reg;
    assign baud_divisor_high = baud_high_reg;
    assign baud_divisor_low  = baud_low_reg;
    assign baud_collision    = collide_reg;
    assign irq               = irq_reg;
endmodule // reset_dependent_sfr_init

// ===== verification/reset_dependent_sfr_init_properties.sv
`timescale 1ns/10ps
// watches how the power-on, watchdog and external reset sources land on the register port
module reset_dependent_sfr_init_checker #(
    parameter logic [7:0] FACTORY_TUNE = 8'h20
) (
    // clock and reset
    input wire logic       clk,
    input wire logic       nrst,
    // reset sources
    input wire logic       pon_rst_pin,
    input wire logic       wdog_rst_pin,
    input wire logic       ext_rst_pin,
    // register port
    input wire logic [7:0] addr,
    input wire logic       wr,
    input wire logic       rd,
    input wire logic [7:0] rdata,
    // outputs
    input wire logic [7:0] port_out_en_n,
    input wire logic [7:0] osc_tune
);
    logic [2:0] quiet_reg = 3'h0;
    logic [2:0] quiet_next;
    logic       tune_wr_reg = 1'b0;
    logic       tune_wr_next;
    // cycles since power-on was high; tune copy may lag a write by one cycle
    always_comb begin
        quiet_next   = pon_rst_pin ? 3'h0 : (quiet_reg == 3'h7 ? quiet_reg : quiet_reg + 3'h1);
        tune_wr_next = wr && addr == sfr_init_pkg::OSC_TUNE_ADDR;
    end
    always_ff @(posedge clk) begin
        quiet_reg   <= quiet_next;
        tune_wr_reg <= tune_wr_next;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    a_ports_hiz_pon: assert property (pon_rst_pin [*4] |=> port_out_en_n == 8'hFF)
        else $error("port enables not released after power-on");
    a_tune_factory_pon: assert property (pon_rst_pin [*4] |=> osc_tune == FACTORY_TUNE)
        else $error("tuning not loaded with factory value");
    a_cause_after_pon: assert property (pon_rst_pin [*4] ##1 !pon_rst_pin ##[3:5]
        (rd && addr == sfr_init_pkg::RESET_CAUSE_ADDR) |=> rdata[5:0] == 6'h30)
        else $error("cause flags wrong after power-on");
    a_wdog_after_pon: assert property (pon_rst_pin [*4] ##1 !pon_rst_pin ##[3:5]
        (rd && addr == sfr_init_pkg::WDOG_CTRL_ADDR) |=> rdata == 8'hE5)
        else $error("watchdog control wrong after power-on");
    a_wdog_timeout_set: assert property (wdog_rst_pin [*4] ##1 !wdog_rst_pin ##[3:5]
        (rd && addr == sfr_init_pkg::WDOG_CTRL_ADDR) |=> rdata == 8'hE7)
        else $error("timeout flag not set by watchdog reset");
    a_cause_ext_set: assert property (ext_rst_pin [*4] ##1 !ext_rst_pin ##[3:5]
        (rd && addr == sfr_init_pkg::RESET_CAUSE_ADDR) |=> rdata[0])
        else $error("external cause flag not set");
    a_tune_kept: assert property (quiet_reg == 3'h7 && !tune_wr_next && !tune_wr_reg |=> $stable(osc_tune))
        else $error("tuning changed without power-on or write");
    a_rdata_idle: assert property (!$past(rd) |-> rdata == 8'h00)
        else $error("read data not zero outside read slot");
endmodule // reset_dependent_sfr_init_checker

bind reset_dependent_sfr_init reset_dependent_sfr_init_checker #(.FACTORY_TUNE(FACTORY_TUNE)) u_chk (
    .clk(clk), .nrst(nrst), .pon_rst_pin(pon_rst_pin), .wdog_rst_pin(wdog_rst_pin),
    .ext_rst_pin(ext_rst_pin), .addr(addr), .wr(wr), .rd(rd), .rdata(rdata),
    .port_out_en_n(port_out_en_n), .osc_tune(osc_tune));

// ===== verification/tb.sv
`timescale 1ns/10ps
// self-checking bench: power-on, each reset source, register port, interrupt
module tb;
    localparam logic [7:0] TUNE = 8'h2B;  // arbitrary factory trim for the run
    logic       clk = 1'b0;
    logic       nrst = 1'b0;
    logic       clk_en = 1'b1;
    logic [5:0] src = 6'h10;  // reset pins, same order as the cause flags
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic       wr = 1'b0;
    logic       rd = 1'b0;
    logic [7:0] rdata, port_out_en_n, osc_tune, baud_divisor_high, baud_divisor_low;
    logic       baud_collision, irq;
    int         n_fail = 0;
    int         tests_run = 0;
    int         seq [6] = '{0, 1, 3, 5, 2, 0};

    reset_dependent_sfr_init #(.FACTORY_TUNE(TUNE)) dut (
        .clk(clk), .nrst(nrst), .clk_en(clk_en), .pon_rst_pin(src[4]), .brownout_rst_pin(src[5]),
        .wdog_rst_pin(src[2]), .soft_rst_pin(src[1]), .ext_rst_pin(src[0]), .break_rst_pin(src[3]),
        .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .port_out_en_n(port_out_en_n),
        .osc_tune(osc_tune), .baud_divisor_high(baud_divisor_high), .baud_divisor_low(baud_divisor_low),
        .baud_collision(baud_collision), .irq(irq));

    // 100 MHz clock
    initial begin
        forever #5 clk = ~clk;
    end

    task end_of_test;
        if (n_fail == 0 && tests_run > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task chk(input string name, input logic [7:0] exp, input logic [7:0] seen);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // one-cycle strobes with an idle edge after, so no strobe is set twice in a step
    task wr_reg(input logic [7:0] a, input logic [7:0] d);
        wr <= 1'b1; addr <= a; wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
        @(posedge clk);
    endtask
    task rd_chk(input logic [7:0] a, input logic [7:0] exp);
        rd <= 1'b1; addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk($sformatf("reg %h", a), exp, rdata);
        @(posedge clk);
    endtask
    // source held four clocks, then three edges for the synchroniser to drain
    task pulse(input int b);
        src[b] <= 1'b1;
        repeat (4) @(posedge clk);
        src[b] <= 1'b0;
        repeat (3) @(posedge clk);
    endtask

    task t_power_on;
        pulse(4);
        rd_chk(sfr_init_pkg::RESET_CAUSE_ADDR, 8'h30);
        rd_chk(sfr_init_pkg::WDOG_CTRL_ADDR, 8'hE5);
        rd_chk(sfr_init_pkg::OSC_TUNE_ADDR, TUNE);
        rd_chk(sfr_init_pkg::RTC_CTRL_ADDR, 8'h60);
        rd_chk(sfr_init_pkg::RTC_HIGH_ADDR, 8'h00);
        rd_chk(sfr_init_pkg::RTC_LOW_ADDR, 8'h00);
        chk("port enables", 8'hFF, port_out_en_n);
        chk("tune output", TUNE, osc_tune);
    endtask
    // every non-power-on source, watchdog fifth so the last pulse sees its flag persist
    task t_sources;
        wr_reg(sfr_init_pkg::OSC_TUNE_ADDR, 8'h5A);
        wr_reg(sfr_init_pkg::RTC_HIGH_ADDR, 8'h12);
        foreach (seq[i]) begin
            wr_reg(sfr_init_pkg::RESET_CAUSE_ADDR, 8'h3F);
            pulse(seq[i]);
            rd_chk(sfr_init_pkg::RESET_CAUSE_ADDR, 8'h01 << seq[i]);
            rd_chk(sfr_init_pkg::WDOG_CTRL_ADDR, i >= 4 ? 8'hE7 : 8'hE5);
            rd_chk(sfr_init_pkg::RTC_HIGH_ADDR, 8'h12);
            chk("tune output", 8'h5A, osc_tune);
        end
    endtask
    task t_sync_reset_irq;
        nrst <= 1'b0;
        @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        rd_chk(sfr_init_pkg::RESET_CAUSE_ADDR, 8'h01);
        rd_chk(sfr_init_pkg::OSC_TUNE_ADDR, 8'h5A);
        rd_chk(sfr_init_pkg::WDOG_CTRL_ADDR, 8'hE7);
        wr_reg(sfr_init_pkg::IRQ_MASK_ADDR, 8'h00);
        pulse(1);
        #1 chk("irq masked", 8'h00, {7'h00, irq});
        wr_reg(sfr_init_pkg::IRQ_MASK_ADDR, 8'h02);
        #1 chk("irq raised", 8'h01, {7'h00, irq});
        wr_reg(sfr_init_pkg::IRQ_STATUS_ADDR, 8'h02);
        #1 chk("irq cleared", 8'h00, {7'h00, irq});
    endtask
    task t_baud_ports;
        wr_reg(sfr_init_pkg::BAUD_CTRL_ADDR, 8'h00);
        wr_reg(sfr_init_pkg::BAUD_HIGH_ADDR, 8'h34);
        wr_reg(sfr_init_pkg::BAUD_LOW_ADDR, 8'h56);
        #1 chk("divisor high", 8'h34, baud_divisor_high);
        chk("divisor low", 8'h56, baud_divisor_low);
        chk("collision idle", 8'h00, {7'h00, baud_collision});
        // frozen clock enable: a divisor write must not land
        clk_en <= 1'b0;
        wr_reg(sfr_init_pkg::BAUD_HIGH_ADDR, 8'h99);
        #1 chk("frozen divisor", 8'h34, baud_divisor_high);
        clk_en <= 1'b1;
        wr_reg(sfr_init_pkg::BAUD_CTRL_ADDR, 8'h01);
        wr_reg(sfr_init_pkg::BAUD_LOW_ADDR, 8'h77);
        #1 chk("collision set", 8'h01, {7'h00, baud_collision});
        rd_chk(8'h00, 8'h00);
        wr_reg(sfr_init_pkg::PORT_MODE_ADDR, 8'h0F);
        #1 chk("port enables", 8'hF0, port_out_en_n);
        chk("collision clear", 8'h00, {7'h00, baud_collision});
    endtask

    // main sequence, second power-on undoes the software values
    initial begin
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        t_power_on();
        t_sources();
        t_sync_reset_irq();
        t_baud_ports();
        @(posedge clk);
        t_power_on();
        end_of_test();
    end
    // hang guard
    initial begin
        #500000;
        n_fail++;
        end_of_test();
    end
endmodule // tb
